// [design/bmc_pkg.sv]
// Purpose: Constants shared by the battery mode controller
// Assumes: 100 MHz system clock, 32768 Hz crystal rate
// Notes:   Register indices times four give byte addresses
package bmc_pkg;

    // ------------------------------------------------------------
    // Clock rates
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned XTAL_HZ       = 32_768;
    localparam int unsigned XTAL_DIV      = (CLK_HZ + XTAL_HZ / 2) / XTAL_HZ;
    localparam int unsigned PLL_SETTLE    = 2048;
    localparam logic [2:0]  BROWN_SKIP    = 3'h7;

    // ------------------------------------------------------------
    // Register indices and field positions
    // ------------------------------------------------------------
    localparam logic [15:0] FLAG_IDX      = 16'h00E8;
    localparam logic [15:0] CTRL_IDX      = 16'h20A9;
    localparam logic [15:0] STAT_IDX      = 16'h2100;
    localparam int unsigned FALL_BIT      = 7;
    localparam int unsigned RISE_BIT      = 6;
    localparam int unsigned TIMER_BIT     = 5;
    localparam int unsigned BUTTON_BIT    = 4;
    localparam int unsigned SLEEP_BIT     = 6;
    localparam int unsigned DISP_BIT      = 5;
    localparam int unsigned DIV_LSB       = 0;
    localparam int unsigned DIV_W         = 3;
    localparam logic [7:0]  FLAG_RST      = 8'h00;
    localparam logic [7:0]  CTRL_RST      = 8'h00;

    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_MISSION = 5'b0_0001,
        ST_BROWN   = 5'b0_0010,
        ST_DISP    = 5'b0_0100,
        ST_SLEEP   = 5'b0_1000,
        ST_SETTLE  = 5'b1_0000
    } bmc_mode_t;

endpackage

// [design/bmc_top.sv]
// Purpose: Battery mode controller with classic Wishbone register slave
// Assumes: Synchronous active-high reset, single 100 MHz clock
// Notes:   Crystal rate is a one-cycle enable from a divider
//
// What this block does
// - With supply present and PLL stable, run in full-power mode.
// - Without supply, be in exactly one of low_supply_mode, display-only or sleep.
// - With margin good, enter low_supply_mode on supply loss and on every wake while on battery.
// - Only from low_supply_mode, firmware request bits move to display-only or sleep.
// - Full-power to low_supply_mode sets the PLL-fall flag, bit 7 of flag register.
// - Return to full-power on PLL stable sets the PLL-rise flag, bit 6.
// - Display-only exits on timer, button, supply return or lost margin; sleep only on timer, button or supply return.
// - Pushbutton rising edge sets the button wake flag, bit 4.
// - Wake timer expiry sets the timer wake flag, bit 5.
// - On battery, lost regulator margin forces sleep from any battery mode.
// - After forced sleep, stay asleep even when margin recovers.
// - Sleep request is bit 6 of control index 0x20A9; writing 0x40 requests it.
// - Processor clock divided PLL in full power, 7/8 crystal in low_supply_mode, else off.
// - Per-mode enables for timer, oscillator, display, engine, filter, analog, flash.
// - Supply return moves any battery mode to full power once PLL settles.
// - Processor held in reset until PLL good, 2048 to 4096 crystal cycles.
// - Button wake starts the processor within three crystal cycles.
`timescale 1ns/1ps
module bmc_top
    import bmc_pkg::*;
#(
    parameter int unsigned XTAL_CYCLES = XTAL_DIV,
    parameter int unsigned SETTLE_TICKS = PLL_SETTLE
)
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [15:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Sense inputs
    input  wire logic        power_sense_above_i,
    input  wire logic        regulator_margin_good_i,
    input  wire logic        pushbutton_pin_i,
    input  wire logic        wake_timer_expire_i,
    // Mode and clocking
    output logic      [4:0]  mode_o,
    output logic             proc_reset_o,
    output logic             proc_clk_en_o,
    output logic             slow_tick_o,
    // Group enables
    output logic             compute_en_o,
    output logic             filter_en_o,
    output logic             analog_en_o,
    output logic             flash_write_en_o,
    output logic             display_en_o,
    output logic             wake_timer_en_o,
    output logic             osc_rtc_en_o,
    output logic             gp_regs_en_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    bmc_mode_t              state_r;
    bmc_mode_t              state_nxt;
    logic [2:0]             meta_r;
    logic [2:0]             sync_r;
    logic                   button_d_r;
    logic [15:0]            xtal_cnt_r;
    logic                   tick;
    logic [2:0]             brown_ph_r;
    logic [DIV_W-1:0]       div_cnt_r;
    logic [12:0]            settle_cnt_r;
    logic [7:0]             flag_r;
    logic [7:0]             ctrl_r;
    logic                   timer_pend_r;
    logic                   button_pend_r;
    logic                   forced_r;
    logic                   ack_r;
    logic                   req;
    logic                   wr_ctrl;
    logic                   wr_flag;
    logic                   supply;
    logic                   margin;
    logic                   button_rise;
    logic                   wake;
    logic                   battery;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
        hit = (a == {idx[13:0], 2'b00});
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
            button_d_r <= 1'b0;
        end
        else
        begin
            meta_r <= {pushbutton_pin_i, regulator_margin_good_i, power_sense_above_i};
            sync_r <= meta_r;
            button_d_r <= sync_r[2];
        end
    end

    assign supply      = sync_r[0];
    assign margin      = sync_r[1];
    assign button_rise = sync_r[2] & ~button_d_r;
    assign battery     = (state_r == ST_BROWN) | (state_r == ST_DISP) | (state_r == ST_SLEEP);

    // ------------------------------------------------------------
    // Crystal-rate enable and processor clock enables
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            xtal_cnt_r <= 16'h0000;
        else if (xtal_cnt_r == 16'(XTAL_CYCLES - 1))
            xtal_cnt_r <= 16'h0000;
        else
            xtal_cnt_r <= xtal_cnt_r + 16'h0001;
    end

    assign tick        = (xtal_cnt_r == 16'(XTAL_CYCLES - 1));
    assign slow_tick_o = tick;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            brown_ph_r <= 3'h0;
        else if (tick)
            brown_ph_r <= brown_ph_r + 3'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || state_r != ST_MISSION)
            div_cnt_r <= '0;
        else if (div_cnt_r == ctrl_r[DIV_LSB +: DIV_W])
            div_cnt_r <= '0;
        else
            div_cnt_r <= div_cnt_r + 1'b1;
    end

    always_comb
    begin
        case (state_r)
            ST_MISSION: proc_clk_en_o = (div_cnt_r == ctrl_r[DIV_LSB +: DIV_W]);
            ST_BROWN:   proc_clk_en_o = tick & (brown_ph_r != BROWN_SKIP);
            default:    proc_clk_en_o = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // PLL settle counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i || state_r != ST_SETTLE)
            settle_cnt_r <= 13'h0000;
        else if (tick)
            settle_cnt_r <= settle_cnt_r + 13'h0001;
    end

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    assign wake = timer_pend_r | button_pend_r;

    always_comb
    begin
        state_nxt = state_r;
        if (tick)
        begin
            case (state_r)
                ST_MISSION:
                begin
                    if (!supply)
                        state_nxt = ST_BROWN;
                end
                ST_SETTLE:
                begin
                    if (!supply)
                        state_nxt = margin ? ST_BROWN : ST_SLEEP;
                    else if (settle_cnt_r == 13'(SETTLE_TICKS - 1))
                        state_nxt = ST_MISSION;
                end
                ST_BROWN:
                begin
                    if (supply)
                        state_nxt = ST_SETTLE;
                    else if (!margin)
                        state_nxt = ST_SLEEP;
                    else if (ctrl_r[SLEEP_BIT])
                        state_nxt = ST_SLEEP;
                    else if (ctrl_r[DISP_BIT])
                        state_nxt = ST_DISP;
                end
                ST_DISP:
                begin
                    if (supply)
                        state_nxt = ST_SETTLE;
                    else if (!margin)
                        state_nxt = ST_SLEEP;
                    else if (wake)
                        state_nxt = ST_BROWN;
                end
                ST_SLEEP:
                begin
                    if (supply)
                        state_nxt = ST_SETTLE;
                    else if (wake && margin)
                        state_nxt = ST_BROWN;
                end
                default: state_nxt = ST_SETTLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_r <= ST_SETTLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || supply)
            forced_r <= 1'b0;
        else if (battery && tick && !margin)
            forced_r <= 1'b1;
    end

    // ------------------------------------------------------------
    // Wake events
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timer_pend_r <= 1'b0;
            button_pend_r <= 1'b0;
        end
        else
        begin
            if (wake_timer_expire_i)
                timer_pend_r <= 1'b1;
            else if (tick)
                timer_pend_r <= 1'b0;
            if (button_rise && !flag_r[BUTTON_BIT])
                button_pend_r <= 1'b1;
            else if (tick)
                button_pend_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    assign req     = cyc_i & stb_i & ~ack_r;
    assign wr_ctrl = req & we_i & sel_i[0] & hit(adr_i, CTRL_IDX);
    assign wr_flag = req & we_i & sel_i[0] & hit(adr_i, FLAG_IDX);
    assign ack_o   = ack_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_r <= 1'b0;
        else
            ack_r <= req;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h0000_0000;
        else if (req && !we_i)
        begin
            if (hit(adr_i, FLAG_IDX))
                dat_o <= {24'h00_0000, flag_r};
            else if (hit(adr_i, CTRL_IDX))
                dat_o <= {24'h00_0000, ctrl_r};
            else if (hit(adr_i, STAT_IDX))
                dat_o <= {24'h00_0000, forced_r, margin, supply, state_r};
            else
                dat_o <= 32'h0000_0000;
        end
    end

    // Both request bits clear on any mode change except into low_supply_mode; a write wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_r <= CTRL_RST;
        else if (wr_ctrl)
            ctrl_r <= dat_i[7:0];
        else if (state_nxt != state_r && state_nxt != ST_BROWN)
        begin
            ctrl_r[SLEEP_BIT] <= 1'b0;
            ctrl_r[DISP_BIT] <= 1'b0;
        end
    end

    // Sticky flags, write one to clear, a new event wins over the clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            flag_r <= FLAG_RST;
        else
        begin
            if (wr_flag)
                flag_r <= flag_r & ~dat_i[7:0];
            if (state_r == ST_MISSION && state_nxt == ST_BROWN)
                flag_r[FALL_BIT] <= 1'b1;
            if (state_r == ST_SETTLE && state_nxt == ST_MISSION)
                flag_r[RISE_BIT] <= 1'b1;
            if (wake_timer_expire_i)
                flag_r[TIMER_BIT] <= 1'b1;
            if (button_rise)
                flag_r[BUTTON_BIT] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Mode outputs and group enables
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            compute_en_o <= 1'b0;
            filter_en_o <= 1'b0;
            analog_en_o <= 1'b0;
            flash_write_en_o <= 1'b0;
            display_en_o <= 1'b0;
            wake_timer_en_o <= 1'b1;
            osc_rtc_en_o <= 1'b1;
            gp_regs_en_o <= 1'b1;
        end
        else
        begin
            compute_en_o <= (state_r == ST_MISSION);
            filter_en_o <= (state_r == ST_MISSION);
            analog_en_o <= (state_r == ST_MISSION);
            flash_write_en_o <= (state_r == ST_MISSION);
            display_en_o <= (state_r != ST_SLEEP) && (state_r != ST_SETTLE);
            wake_timer_en_o <= 1'b1;
            osc_rtc_en_o <= 1'b1;
            gp_regs_en_o <= 1'b1;
        end
    end

    assign mode_o       = state_r;
    assign proc_reset_o = (state_r == ST_SETTLE) | (state_r == ST_DISP) | (state_r == ST_SLEEP);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    fall_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_MISSION && state_nxt == ST_BROWN) |=> flag_r[FALL_BIT])
        else $error("PLL fall flag not set on mode drop");

    rise_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_MISSION && $past(state_r) != ST_MISSION) |-> flag_r[RISE_BIT])
        else $error("PLL rise flag missing on return to full power");

    sleep_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_SLEEP && tick && !wake && !supply) |=> state_r == ST_SLEEP)
        else $error("Sleep left without wake cause");

    margin_sleep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (battery && tick && !margin && !supply) |=> state_r == ST_SLEEP)
        else $error("Low margin did not force sleep");

    clock_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_DISP || state_r == ST_SLEEP) |-> !proc_clk_en_o)
        else $error("Processor clock running in low mode");

    brown_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_BROWN && tick) |-> proc_clk_en_o == (brown_ph_r != BROWN_SKIP))
        else $error("Low_supply_mode clock rate wrong");

    settle_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r != ST_MISSION ##1 state_r == ST_MISSION)
        |-> $past(state_r) == ST_SETTLE && $past(settle_cnt_r) == 13'(SETTLE_TICKS - 1))
        else $error("Full power entered before PLL settle");

    button_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        button_rise |=> flag_r[BUTTON_BIT])
        else $error("Button flag not set");

    timer_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_timer_expire_i |=> flag_r[TIMER_BIT] ##0 timer_pend_r)
        else $error("Timer flag not set");

    sleep_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_BROWN && tick && supply == 1'b0 && margin && ctrl_r[SLEEP_BIT])
        |=> state_r == ST_SLEEP)
        else $error("Sleep request ignored in low_supply_mode");

    display_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_SLEEP [*2]) |-> !display_en_o && !compute_en_o)
        else $error("Enables wrong in sleep");

endmodule

// [bench/bmc_env.sv]
// Purpose: Far-side model of supply comparator, pushbutton and wake timer
// Assumes: Bench changes request levels just after a rising clock edge
// Notes:   A timer request gives a single one-cycle expiry pulse
`timescale 1ns/1ps
module bmc_env
(
    // Clock
    input  wire logic clk_i,
    // Requests from the bench
    input  wire logic supply_i,
    input  wire logic margin_i,
    input  wire logic press_i,
    input  wire logic timer_i,
    // Pins toward the block
    output logic      sense_o,
    output logic      margin_o,
    output logic      button_o,
    output logic      expire_o
);
    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    logic timer_q;

    always_ff @(posedge clk_i)
    begin
        timer_q <= timer_i;
    end

    // Button pin is pulled low whenever it is not pressed
    assign sense_o  = supply_i;
    assign margin_o = margin_i;
    assign button_o = press_i;
    assign expire_o = timer_i & ~timer_q;
endmodule

// [bench/testbench.sv]
// Purpose: Self-checking bench for the battery mode controller
// Assumes: Shortened crystal divider and settle count
// Notes:   Firmware is played by the Wishbone tasks
`timescale 1ns/1ps
module testbench;
    import bmc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [15:0] A_FLAG = {FLAG_IDX[13:0], 2'b00};
    localparam logic [15:0] A_CTRL = {CTRL_IDX[13:0], 2'b00};
    localparam logic [15:0] A_STAT = {STAT_IDX[13:0], 2'b00};
    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic        cyc  = 1'b0;
    logic        stb  = 1'b0;
    logic        we   = 1'b0;
    logic [15:0] adr  = 16'h0000;
    logic [3:0]  sel  = 4'h1;
    logic [31:0] wdat = 32'h0000_0000;
    logic        sup  = 1'b1;
    logic        mar  = 1'b1;
    logic        prs  = 1'b0;
    logic        tmr  = 1'b0;
    wire logic [31:0] rdat;
    wire logic [4:0]  mode;
    wire logic [7:0]  en;
    wire logic        ack, prst, pclk, sense, margin, button, expire, tick;
    logic [7:0]  q;
    int          c, tk, wn;
    int          n_mismatch = 0;
    int          compares   = 0;

    always #5 clk = ~clk;

    bmc_env ENV (.clk_i(clk), .supply_i(sup), .margin_i(mar), .press_i(prs),
        .timer_i(tmr), .sense_o(sense), .margin_o(margin), .button_o(button),
        .expire_o(expire));

    bmc_top #(.XTAL_CYCLES(4), .SETTLE_TICKS(4)) DUT (.clk_i(clk), .rst_i(rst),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .power_sense_above_i(sense),
        .regulator_margin_good_i(margin), .pushbutton_pin_i(button),
        .wake_timer_expire_i(expire), .mode_o(mode), .proc_reset_o(prst),
        .proc_clk_en_o(pclk), .slow_tick_o(tick), .compute_en_o(en[7]),
        .filter_en_o(en[6]), .analog_en_o(en[5]), .flash_write_en_o(en[4]),
        .display_en_o(en[3]), .wake_timer_en_o(en[2]), .osc_rtc_en_o(en[1]),
        .gp_regs_en_o(en[0]));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h00_0000, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat[7:0];
        chk("ack", 32'h1, {31'h0, ack});
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wait_mode(input bmc_mode_t m);
        wn = 0;
        while (mode !== m && wn < 400)
        begin
            @(posedge clk);
            wn++;
        end
        chk("mode", {27'h0, m}, {27'h0, mode});
        repeat (2) @(posedge clk);
    endtask

    task automatic count_clk(input int n);
        c = 0;
        tk = 0;
        repeat (n)
        begin
            @(posedge clk);
            if (pclk === 1'b1)
                c++;
            if (tick === 1'b1)
                tk++;
        end
    endtask

    task automatic flags(input logic [7:0] e);
        wb(1'b0, A_FLAG, 8'h00);
        chk("flags", {24'h0, e}, {24'h0, q});
        wb(1'b1, A_FLAG, 8'hFF);
        wb(1'b0, A_FLAG, 8'h00);
        chk("flags cleared", 32'h0, {24'h0, q});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_power_up;
        @(posedge clk);
        chk("mode settle", {27'h0, ST_SETTLE}, {27'h0, mode});
        chk("proc reset", 32'h1, {31'h0, prst});
        wait_mode(ST_MISSION);
        chk("proc reset", 32'h0, {31'h0, prst});
        chk("enables", 32'hFF, {24'h0, en});
        flags(8'h40);
        $display("test power_up done");
    endtask

    task automatic t_refuse;
        wb(1'b1, A_CTRL, 8'h43);
        repeat (40) @(posedge clk);
        chk("mode", {27'h0, ST_MISSION}, {27'h0, mode});
        count_clk(64);
        chk("clock pulses", 32'd16, c);
        chk("slow ticks", 32'd16, tk);
        wb(1'b0, 16'h0004, 8'h00);
        chk("unmapped", 32'h0, {24'h0, q});
        wb(1'b1, A_CTRL, 8'h00);
        wb(1'b0, A_CTRL, 8'h00);
        chk("ctrl", 32'h0, {24'h0, q});
        $display("test refuse done");
    endtask

    task automatic t_brown;
        sup <= 1'b0;
        wait_mode(ST_BROWN);
        chk("enables", 32'h0F, {24'h0, en});
        count_clk(64);
        chk("clock pulses", 32'd14, c);
        flags(8'h80);
        $display("test low_supply_mode done");
    endtask

    task automatic t_disp;
        wb(1'b1, A_CTRL, 8'h20);
        wait_mode(ST_DISP);
        chk("enables", 32'h0F, {24'h0, en});
        count_clk(40);
        chk("clock pulses", 32'd0, c);
        chk("mode", {27'h0, ST_DISP}, {27'h0, mode});
        prs <= 1'b1;
        wait_mode(ST_BROWN);
        chk("wake in time", 32'h1, {31'h0, wn <= 12});
        chk("proc reset", 32'h0, {31'h0, prst});
        prs <= 1'b0;
        flags(8'h10);
        $display("test display done");
    endtask

    task automatic t_sleep;
        // Press in low_supply_mode leaves the button flag set
        prs <= 1'b1;
        repeat (8) @(posedge clk);
        prs <= 1'b0;
        // Firmware path from low_supply_mode to sleep
        wb(1'b1, A_CTRL, 8'h40);
        wait_mode(ST_SLEEP);
        chk("enables", 32'h07, {24'h0, en});
        wb(1'b0, A_CTRL, 8'h00);
        chk("ctrl", 32'h0, {24'h0, q});
        prs <= 1'b1;
        repeat (40) @(posedge clk);
        chk("button held off", {27'h0, ST_SLEEP}, {27'h0, mode});
        prs <= 1'b0;
        tmr <= 1'b1;
        @(posedge clk);
        tmr <= 1'b0;
        wait_mode(ST_BROWN);
        flags(8'h30);
        $display("test sleep done");
    endtask

    task automatic t_forced;
        mar <= 1'b0;
        wait_mode(ST_SLEEP);
        mar <= 1'b1;
        repeat (40) @(posedge clk);
        chk("mode", {27'h0, ST_SLEEP}, {27'h0, mode});
        wb(1'b0, A_STAT, 8'h00);
        chk("status", 32'hC8, {24'h0, q});
        sup <= 1'b1;
        wait_mode(ST_MISSION);
        chk("settle time", 32'h1, {31'h0, wn >= 16 && wn <= 32});
        flags(8'h40);
        $display("test forced_sleep done");
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic wrap_up;
        $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up;
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_power_up;
        t_refuse;
        t_brown;
        t_disp;
        t_sleep;
        t_forced;
        wrap_up;
    end
endmodule
